// ---- pkg/src_consts.svh ----
// offsets, field positions, reset values and timing counts of the reclocker control
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH

// register byte addresses
`define SRC_CTRL_ADDR 4'h0
`define SRC_STATUS_ADDR 4'h4

// control register fields
`define SRC_CTRL_FORCE_BYPASS 0
`define SRC_CTRL_RATE_LO 1
`define SRC_CTRL_RATE_HI 2
`define SRC_CTRL_INSEL_LO 3
`define SRC_CTRL_INSEL_HI 4
`define SRC_CTRL_CLKSEL 5
`define SRC_CTRL_MUTE_N 6
`define SRC_CTRL_WIDTH 7
`define SRC_CTRL_RESET 7'h40

// status register fields
`define SRC_STAT_LOCK 0
`define SRC_STAT_LOW_RATE 1
`define SRC_STAT_BYPASS 2
`define SRC_STAT_TEST 3
`define SRC_STAT_IND_VALID 4

// rate select codes
`define SRC_RSEL_AUTO 2'h0
`define SRC_RSEL_SD 2'h1
`define SRC_RSEL_HD 2'h2
`define SRC_RSEL_TEST 2'h3

// timing
`define SRC_CLK_PERIOD_NS 5
`define SRC_ACQ_MAX_MS 15
`define SRC_ACQ_CYCLES (`SRC_ACQ_MAX_MS * 1000000 / `SRC_CLK_PERIOD_NS)
`define SRC_LOSS_MAX_MS 1
`define SRC_LOSS_CYCLES (`SRC_LOSS_MAX_MS * 1000000 / `SRC_CLK_PERIOD_NS)
`define SRC_IND_DELAY_NS 37
`define SRC_IND_CYCLES ((`SRC_IND_DELAY_NS + `SRC_CLK_PERIOD_NS - 1) / `SRC_CLK_PERIOD_NS)
`define SRC_SETTLE_CYCLES 64
`define SRC_CNT_W 22

`endif

// ---- pkg/src_pkg.sv ----
// types of the reclocker control: detected rates, lock states, state record
`include "src_consts.svh"

package src_pkg;

    typedef enum logic [3:0] {
        SRC_RATE_NONE = 4'h0,
        SRC_RATE_270 = 4'h1,
        SRC_RATE_1483 = 4'h2,
        SRC_RATE_1485 = 4'h3,
        SRC_RATE_2967 = 4'h4,
        SRC_RATE_2970 = 4'h5,
        SRC_RATE_143 = 4'h6,
        SRC_RATE_177 = 4'h7,
        SRC_RATE_360 = 4'h8,
        SRC_RATE_540 = 4'h9,
        SRC_RATE_HARMONIC = 4'ha
    } src_rate_t;

    typedef enum logic [2:0] {
        SRC_ST_IDLE = 3'b001,
        SRC_ST_ACQ = 3'b010,
        SRC_ST_LOCK = 3'b100
    } src_state_t;

    typedef struct packed {
        logic [3:0] in_meta;
        logic [3:0] in_sync;
        logic prev_bit;
        logic retimed;
        logic rclk;
        src_state_t state;
        logic [`SRC_CNT_W-1:0] settle_cnt;
        logic [`SRC_CNT_W-1:0] quiet_cnt;
        src_rate_t lock_rate;
        logic [3:0] ind_cnt;
        logic low_rate;
        logic ind_valid;
        logic [`SRC_CTRL_WIDTH-1:0] ctrl;
        logic ack;
        logic [31:0] rdata;
        logic pri_p;
        logic pri_n;
        logic sec_p;
        logic sec_n;
    } src_state_rec_t;

endpackage

// ---- rtl/src_reclocker_ctrl.sv ----
// control and status logic of a serial-video reclocker with wishbone registers
//
// Behaviour
// - lock rises within 15 ms of the first transition on the chosen input
// - rate indicator becomes valid one reference period after lock changes
// - an input change drops lock within 1 ms; indicator invalid meanwhile
// - second output carries recovered clock when selected high, else data copy
// - second output clock select defaults low, giving a second data output
// - mute low silences both the primary and the second output
// - bypass with second output as clock mutes the second output
// - a muted pair holds static opposite levels on its two legs
// - lock only at 270, 1483, 1485, 2967, 2970 Mbps, never harmonics
// - 143, 177, 360, 540 Mbps stay unlocked and force bypass
// - unsupported rate in auto bypass with clock output mutes the second output
// - rate select: 00 auto, 01 forces 270, 10 forces the fast group
// - both rate select bits default low, giving automatic detection
// - rate select can also place the device in a test mode
// - forced 270 mode reclocks 8b10b transport data without harmonic lock
// - outside party picks one of four inputs, device routes it to reclocker
// - input select 00..11 picks input 0..3, default 00
// - force bypass passes data unclocked, holds lock low; else bypass if unlocked
// - indicator high for 270, low for faster rates, low while unlocked once valid again
`timescale 1ns/1ps
`include "src_consts.svh"

module src_reclocker_ctrl
    import src_pkg::*;
#(
    parameter int ACQ_CYCLES = `SRC_ACQ_CYCLES,
    parameter int LOSS_CYCLES = `SRC_LOSS_CYCLES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial side
    input wire logic [3:0] serial_inputs_i,
    input wire src_rate_t detected_rate_i,
    output logic primary_serial_out_p_o,
    output logic primary_serial_out_n_o,
    output logic second_serial_out_p_o,
    output logic second_serial_out_n_o,
    // indicators
    output logic lock_o,
    output logic low_rate_indicator_o
);

    localparam logic [`SRC_CNT_W-1:0] SETTLE = `SRC_CNT_W'(`SRC_SETTLE_CYCLES);
    localparam logic [`SRC_CNT_W-1:0] LOSS = `SRC_CNT_W'(LOSS_CYCLES);
    localparam logic [3:0] IND_DLY = 4'(`SRC_IND_CYCLES);

    src_state_rec_t cur;
    src_state_rec_t next_cur;

    logic force_bypass;
    logic [1:0] rate_sel;
    logic [1:0] in_sel;
    logic clk_sel;
    logic mute_n;
    logic test_mode;
    logic sel_bit;
    logic transition;
    logic supported;
    logic acceptable;
    logic locked;
    logic bypass;
    logic wb_req;
    logic [31:0] status;

    ////////////////////////////////////////////////////////////////////////
    // control decode

    assign force_bypass = cur.ctrl[`SRC_CTRL_FORCE_BYPASS];
    assign rate_sel = cur.ctrl[`SRC_CTRL_RATE_HI:`SRC_CTRL_RATE_LO];
    assign in_sel = cur.ctrl[`SRC_CTRL_INSEL_HI:`SRC_CTRL_INSEL_LO];
    assign clk_sel = cur.ctrl[`SRC_CTRL_CLKSEL];
    assign mute_n = cur.ctrl[`SRC_CTRL_MUTE_N];
    assign test_mode = (rate_sel == `SRC_RSEL_TEST);
    assign sel_bit = cur.in_sync[in_sel];
    assign transition = sel_bit ^ cur.prev_bit;
    assign locked = (cur.state == SRC_ST_LOCK);
    assign bypass = force_bypass | ~locked;
    assign wb_req = wb_cyc_i & wb_stb_i;

    // harmonics and the low rates never count as supported
    always_comb
    begin
        supported = 1'b0;
        acceptable = 1'b0;
        unique case (detected_rate_i)
            SRC_RATE_270, SRC_RATE_1483, SRC_RATE_1485, SRC_RATE_2967, SRC_RATE_2970:
                supported = 1'b1;
            default:
                supported = 1'b0;
        endcase
        unique case (rate_sel)
            `SRC_RSEL_AUTO:
                acceptable = supported;
            `SRC_RSEL_SD:
                acceptable = (detected_rate_i == SRC_RATE_270);
            `SRC_RSEL_HD:
                acceptable = supported & (detected_rate_i != SRC_RATE_270);
            default:
                acceptable = 1'b0;
        endcase
    end

    always_comb
    begin
        status = 32'h0;
        status[`SRC_STAT_LOCK] = lock_o;
        status[`SRC_STAT_LOW_RATE] = cur.low_rate;
        status[`SRC_STAT_BYPASS] = bypass;
        status[`SRC_STAT_TEST] = test_mode;
        status[`SRC_STAT_IND_VALID] = cur.ind_valid;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_cur = cur;
        // two stages before any logic sees the pins
        next_cur.in_meta = serial_inputs_i;
        next_cur.in_sync = cur.in_meta;
        next_cur.prev_bit = sel_bit;
        next_cur.retimed = sel_bit;
        next_cur.rclk = ~cur.rclk;

        // wishbone: ack one cycle after the request, dropped the cycle after
        next_cur.ack = wb_req & ~cur.ack;
        next_cur.rdata = 32'h0;
        if (wb_req && !cur.ack)
        begin
            if (wb_we_i && wb_adr_i == `SRC_CTRL_ADDR && wb_sel_i[0])
            begin
                next_cur.ctrl = wb_dat_i[`SRC_CTRL_WIDTH-1:0];
            end
            if (!wb_we_i && wb_adr_i == `SRC_CTRL_ADDR)
            begin
                next_cur.rdata = {{(32-`SRC_CTRL_WIDTH){1'b0}}, cur.ctrl};
            end
            if (!wb_we_i && wb_adr_i == `SRC_STATUS_ADDR)
            begin
                next_cur.rdata = status;
            end
        end

        // lock state machine
        next_cur.quiet_cnt = transition ? '0 : cur.quiet_cnt + `SRC_CNT_W'(1);
        unique case (cur.state)
            SRC_ST_IDLE:
            begin
                next_cur.settle_cnt = '0;
                if (transition && !force_bypass)
                begin
                    next_cur.state = SRC_ST_ACQ;
                end
            end
            SRC_ST_ACQ:
            begin
                // rate must hold steady; a change restarts the settle count
                if (!acceptable || detected_rate_i != cur.lock_rate)
                begin
                    next_cur.settle_cnt = '0;
                end
                else if (cur.settle_cnt != SETTLE)
                begin
                    next_cur.settle_cnt = cur.settle_cnt + `SRC_CNT_W'(1);
                end
                next_cur.lock_rate = detected_rate_i;
                if (acceptable && cur.settle_cnt == SETTLE)
                begin
                    next_cur.state = SRC_ST_LOCK;
                end
            end
            SRC_ST_LOCK:
            begin
                // any change of the detected rate drops lock at once
                if (detected_rate_i != cur.lock_rate || !acceptable)
                begin
                    next_cur.state = SRC_ST_IDLE;
                end
            end
            default:
            begin
                next_cur.state = SRC_ST_IDLE;
            end
        endcase
        if (force_bypass || cur.quiet_cnt >= LOSS)
        begin
            next_cur.state = SRC_ST_IDLE;
        end
        if (wb_req && !cur.ack && wb_we_i && wb_adr_i == `SRC_CTRL_ADDR && wb_sel_i[0]
            && wb_dat_i[`SRC_CTRL_WIDTH-1:0] != cur.ctrl)
        begin
            next_cur.state = SRC_ST_IDLE;
        end

        // indicator follows lock after one reference period
        if (next_cur.state[2] != cur.state[2])
        begin
            next_cur.ind_cnt = IND_DLY;
            next_cur.ind_valid = 1'b0;
        end
        else if (cur.ind_cnt != 4'h0)
        begin
            next_cur.ind_cnt = cur.ind_cnt - 4'h1;
            if (cur.ind_cnt == 4'h1)
            begin
                next_cur.low_rate = locked & (cur.lock_rate == SRC_RATE_270);
                next_cur.ind_valid = 1'b1;
            end
        end

        // output pairs; a muted pair parks at p low, n high
        next_cur.pri_p = 1'b0;
        next_cur.pri_n = 1'b1;
        next_cur.sec_p = 1'b0;
        next_cur.sec_n = 1'b1;
        if (mute_n)
        begin
            next_cur.pri_p = bypass ? sel_bit : cur.retimed;
            next_cur.pri_n = ~next_cur.pri_p;
            if (!clk_sel)
            begin
                next_cur.sec_p = next_cur.pri_p;
                next_cur.sec_n = ~next_cur.pri_p;
            end
            else if (!bypass)
            begin
                next_cur.sec_p = cur.rclk;
                next_cur.sec_n = ~cur.rclk;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur <= '0;
            cur.state <= SRC_ST_IDLE;
            cur.lock_rate <= SRC_RATE_NONE;
            cur.ctrl <= `SRC_CTRL_RESET;
            cur.pri_n <= 1'b1;
            cur.sec_n <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign wb_ack_o = cur.ack;
    assign wb_dat_o = cur.rdata;
    assign lock_o = locked & ~force_bypass;
    assign low_rate_indicator_o = cur.low_rate;
    assign primary_serial_out_p_o = cur.pri_p;
    assign primary_serial_out_n_o = cur.pri_n;
    assign second_serial_out_p_o = cur.sec_p;
    assign second_serial_out_n_o = cur.sec_n;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_lock_after_settle: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur.state == SRC_ST_ACQ && acceptable && cur.settle_cnt == SETTLE && !force_bypass
         && cur.quiet_cnt < LOSS && !(wb_req && wb_we_i)) |=> locked)
        else $error("acquisition did not lock after settle");

    a_acq_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur.state == SRC_ST_ACQ) |-> (int'(cur.settle_cnt) < ACQ_CYCLES))
        else $error("settle count beyond acquisition bound");

    a_quiet_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        (locked && cur.quiet_cnt >= LOSS) |=> !locked)
        else $error("lock held on a quiet input");

    a_second_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        (mute_n && !clk_sel) |=> (second_serial_out_p_o == primary_serial_out_p_o))
        else $error("second output not a data copy");

    a_bypass_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (mute_n && bypass) |=> (primary_serial_out_p_o == $past(sel_bit)))
        else $error("bypassed data not passed through");

    a_test_no_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        test_mode |-> !lock_o)
        else $error("lock in test mode");

    a_ind_matches: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_o && cur.ind_valid) |-> (low_rate_indicator_o == (cur.lock_rate == SRC_RATE_270)))
        else $error("indicator disagrees with locked rate");

    a_ind_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(lock_o) && !force_bypass ##0 (lock_o && !force_bypass)[*8] |=> cur.ind_valid)
        else $error("rate indicator late after lock");

    a_rate_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        (locked && detected_rate_i != cur.lock_rate) |=> !lock_o)
        else $error("lock held after rate change");

    a_clock_out: assert property (@(posedge clk_i) disable iff (rst_i)
        (mute_n && clk_sel && !bypass) |=> (second_serial_out_p_o == $past(cur.rclk)))
        else $error("second output not carrying clock");

    a_mute_static: assert property (@(posedge clk_i) disable iff (rst_i)
        !mute_n |=> (!primary_serial_out_p_o && primary_serial_out_n_o && !second_serial_out_p_o))
        else $error("muted output not static");

    a_bypass_clk_mute: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_sel && bypass) |=> (!second_serial_out_p_o && second_serial_out_n_o))
        else $error("clock output live in bypass");

    a_pair_opposite: assert property (@(posedge clk_i) disable iff (rst_i)
        (primary_serial_out_p_o != primary_serial_out_n_o) && (second_serial_out_p_o != second_serial_out_n_o))
        else $error("pair legs not opposite");

    a_no_bad_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        lock_o |-> $past(acceptable))
        else $error("locked to an unsupported rate");

    a_force_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        force_bypass |-> !lock_o)
        else $error("lock high under forced bypass");

    a_ind_low_unlocked: assert property (@(posedge clk_i) disable iff (rst_i)
        (!lock_o && cur.ind_valid) |-> !low_rate_indicator_o)
        else $error("indicator high while unlocked");

endmodule

// ---- dv/src_feed_model.sv ----
// upstream equalizer stand-in: serial stream on one chosen line plus rate report
`timescale 1ns/1ps

module src_feed_model
    import src_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // scenario control
    input wire logic run_i,
    input wire logic [1:0] line_i,
    input wire src_rate_t rate_i,
    // toward the reclocker
    output logic [3:0] serial_o,
    output src_rate_t rate_o
);
    logic [6:0] lfsr;

    ////////////////////////////////////////////////////////////////////////
    // idle lines sit low: no carrier means no transitions to lock onto
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lfsr <= 7'h5a;
            serial_o <= 4'h0;
            rate_o <= SRC_RATE_NONE;
        end
        else
        begin
            lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
            serial_o <= run_i ? ((4'h1 << line_i) & {4{lfsr[0]}}) : 4'h0;
            rate_o <= rate_i;
        end
    end
endmodule

// ---- dv/test_src_reclocker_ctrl.sv ----
// self-checking bench of the reclocker control block
`timescale 1ns/1ps
`include "src_consts.svh"

module test_src_reclocker_ctrl
    import src_pkg::*;
;
    typedef struct packed {logic [1:0] rsel; src_rate_t rate; logic lock; logic low;} src_row_t;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic run = 1'h0;
    logic [1:0] line = 2'h2;
    src_rate_t rate = SRC_RATE_NONE;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] ser;
    src_rate_t det;
    logic pp, pn, sp, sn, lock, low, prev, seen;
    int mismatches = 0;
    int compares = 0;
    src_row_t rows [0:13] = '{
        '{`SRC_RSEL_AUTO, SRC_RATE_270, 1'h1, 1'h1}, '{`SRC_RSEL_AUTO, SRC_RATE_1483, 1'h1, 1'h0},
        '{`SRC_RSEL_AUTO, SRC_RATE_1485, 1'h1, 1'h0}, '{`SRC_RSEL_AUTO, SRC_RATE_2967, 1'h1, 1'h0},
        '{`SRC_RSEL_AUTO, SRC_RATE_2970, 1'h1, 1'h0}, '{`SRC_RSEL_AUTO, SRC_RATE_143, 1'h0, 1'h0},
        '{`SRC_RSEL_AUTO, SRC_RATE_177, 1'h0, 1'h0}, '{`SRC_RSEL_AUTO, SRC_RATE_360, 1'h0, 1'h0},
        '{`SRC_RSEL_AUTO, SRC_RATE_540, 1'h0, 1'h0}, '{`SRC_RSEL_AUTO, SRC_RATE_HARMONIC, 1'h0, 1'h0},
        '{`SRC_RSEL_SD, SRC_RATE_270, 1'h1, 1'h1}, '{`SRC_RSEL_SD, SRC_RATE_HARMONIC, 1'h0, 1'h0},
        '{`SRC_RSEL_HD, SRC_RATE_1485, 1'h1, 1'h0}, '{`SRC_RSEL_TEST, SRC_RATE_270, 1'h0, 1'h0}};

    always #2.5 clk_i = ~clk_i;

    src_feed_model feed (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .line_i(line), .rate_i(rate),
        .serial_o(ser), .rate_o(det));

    // short counts keep the run brief; acquisition is only an upper bound
    src_reclocker_ctrl #(.ACQ_CYCLES(400), .LOSS_CYCLES(200)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_inputs_i(ser),
        .detected_rate_i(det), .primary_serial_out_p_o(pp), .primary_serial_out_n_o(pn),
        .second_serial_out_p_o(sp), .second_serial_out_n_o(sn), .lock_o(lock),
        .low_rate_indicator_o(low));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 20);
        chk("ack", 1'h1, wb_ack_o);
        rd = wb_dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wait_lock(input logic lvl, input int max);
        int n;
        n = 0;
        while (lock !== lvl && n < max)
        begin
            @(posedge clk_i);
            n++;
        end
        chk("lock", lvl, lock);
    endtask

    // quiet the line first so the next transition is the first one
    task automatic start(input logic [31:0] c);
        run <= 1'h0;
        wait_lock(1'h0, 220);
        // indicator only settles low some cycles after lock falls
        repeat (9) @(posedge clk_i);
        wb(1'h1, `SRC_CTRL_ADDR, c);
        run <= 1'h1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        $display("unexpected watchdog: expected done, seen timeout");
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        chk("outputs in reset", 4'h5, {pp, pn, sp, sn});
        rst_i <= 1'h0;
        run <= 1'h1;
        wb(1'h0, `SRC_CTRL_ADDR, 32'h0);
        chk("ctrl reset", `SRC_CTRL_RESET, rd);
        foreach (rows[i])
        begin
            start(32'h50 | (32'(rows[i].rsel) << 1));
            rate <= rows[i].rate;
            chk("indicator unlocked", 1'h0, low);
            if (rows[i].lock)
            begin
                wait_lock(1'h1, 400);
                repeat (9) @(posedge clk_i);
            end
            else
                repeat (150) @(posedge clk_i);
            chk("lock", rows[i].lock, lock);
            chk("indicator", rows[i].low, low);
            wb(1'h0, `SRC_STATUS_ADDR, 32'h0);
            chk("status", {rows[i].rsel == 2'h3, ~rows[i].lock, rows[i].low, rows[i].lock}, rd[3:0]);
            $display("row %0d done", i);
        end
        rate <= SRC_RATE_270;
        start(32'h72);
        wait_lock(1'h1, 400);
        // first cycle after lock still shows the muted level
        @(posedge clk_i);
        prev = sp;
        repeat (4)
        begin
            @(posedge clk_i);
            chk("clock toggle", !prev, sp);
            chk("clock pair", !sp, sn);
            prev = sp;
        end
        start(32'h52);
        wait_lock(1'h1, 400);
        repeat (4)
        begin
            @(posedge clk_i);
            chk("data copy", pp, sp);
        end
        $display("second output test done");
        wb(1'h1, `SRC_CTRL_ADDR, 32'h12);
        repeat (3)
        begin
            @(posedge clk_i);
            chk("muted outputs", 4'h5, {pp, pn, sp, sn});
        end
        start(32'h71);
        seen = 1'h0;
        prev = pp;
        repeat (150)
        begin
            @(posedge clk_i);
            if (pp !== prev)
                seen = 1'h1;
            prev = pp;
        end
        chk("lock in bypass", 1'h0, lock);
        chk("second muted", 2'h1, {sp, sn});
        chk("bypass data moves", 1'h1, seen);
        $display("mute and bypass test done");
        start(32'h48);
        repeat (150) @(posedge clk_i);
        chk("lock on idle input", 1'h0, lock);
        line <= 2'h1;
        wait_lock(1'h1, 400);
        wb(1'h1, `SRC_CTRL_ADDR, 32'h50);
        wait_lock(1'h0, 200);
        wb(1'h0, 4'h8, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("routing test done");
        line <= 2'h2;
        wait_lock(1'h1, 400);
        rate <= SRC_RATE_1485;
        wait_lock(1'h0, 20);
        wb(1'h0, `SRC_STATUS_ADDR, 32'h0);
        chk("indicator valid after change", 1'h0, rd[`SRC_STAT_IND_VALID]);
        wait_lock(1'h1, 400);
        repeat (9) @(posedge clk_i);
        chk("indicator fast rate", 1'h0, low);
        rate <= SRC_RATE_270;
        wait_lock(1'h0, 20);
        wait_lock(1'h1, 400);
        repeat (9) @(posedge clk_i);
        chk("indicator before reset", 1'h1, low);
        $display("rate change test done");
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        chk("lock in reset", 1'h0, lock);
        chk("indicator in reset", 1'h0, low);
        rst_i <= 1'h0;
        wb(1'h0, `SRC_CTRL_ADDR, 32'h0);
        chk("ctrl after reset", `SRC_CTRL_RESET, rd);
        $display("reset test done");
        finish_test();
    end
endmodule
